/* src/ptsu_timestamp_unit.sv */
// Timestamp unit: seconds/nanoseconds timer with PTP event capture.
// Function
// - The timer holds 32 bits of seconds above 30 bits of nanoseconds.
// - When nanoseconds reach one second they wrap and seconds increment.
// - Each seconds increment from a nanosecond wrap raises an event; a host adjustment of seconds does not.
// - A PTP event frame latches the time into a capture register and raises an event.
// - The host can read, overwrite and adjust the running time.
// - Each enabled cycle without a host write, the nanoseconds advance by the 8-bit whole-nanosecond step.
// - A 16-bit fractional step accumulates for sub-nanosecond resolution.
// - On 011B19000000, type 00 is sync and 01 is delay request.
// - On 0180C200000E, type 00 is sync, 02 peer delay request, 03 peer response.
// - Raw frames carry ethertype 88F7 at 12-13, type at 14, version 02 at 15.
// - UDP/IPv6 frames carry port 013F at 56-57, type at 62, version at 94.
module ptsu_timestamp_unit (
  input  wire logic                          sys_clk_i,
  input  wire logic                          resetn_i,
  input  wire logic                          en_i,
  input  wire logic [ptsu_pkg::STEP_W-1:0]   timer_increment_setting_i,
  input  wire logic [ptsu_pkg::FRAC_W-1:0]   timer_increment_fraction_setting_i,
  input  wire ptsu_pkg::ptsu_host_t          host_i,
  input  wire ptsu_pkg::ptsu_octet_t         octet_i,
  output ptsu_pkg::ptsu_time_t               time_o,
  output ptsu_pkg::ptsu_time_t               capture_o [ptsu_pkg::NUM_KINDS],
  output logic                               sec_evt_o,
  output logic                               capture_evt_o,
  output ptsu_pkg::ptsu_kind_t               capture_kind_o
);

  logic [ptsu_pkg::FRAC_W-1:0] frac;
  logic [ptsu_pkg::FRAC_W:0]   frac_sum;
  logic                        carry;
  logic [31:0]                 ns_inc;
  logic [31:0]                 ns_adj;
  logic [31:0]                 ns_sum;
  ptsu_pkg::ptsu_time_t        next_time;
  logic                        next_sec_evt;
  ptsu_pkg::ptsu_time_t        snap;
  ptsu_pkg::ptsu_time_t        snap_hold;
  logic                        hit;
  ptsu_pkg::ptsu_kind_t        kind;

  assign frac_sum = {1'b0, frac}
                  + {1'b0, timer_increment_fraction_setting_i};
  assign carry    = frac_sum[ptsu_pkg::FRAC_W];
  assign ns_inc   = {2'h0, time_o.ns}
                  + {24'h000000, timer_increment_setting_i}
                  + {31'h00000000, carry};
  assign ns_adj   = {2'h0, host_i.value.ns};

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frac <= '0;
    end else if (en_i) begin
      frac <= frac_sum[ptsu_pkg::FRAC_W-1:0];
    end
  end

  // Write, adjustment and the cycle's step are resolved in one next value.
  always_comb begin
    next_time    = time_o;
    next_sec_evt = 1'b0;
    ns_sum       = ns_inc;
    if (host_i.wr) begin
      next_time = host_i.value;
    end else if (host_i.adj && host_i.sub && ns_inc < ns_adj) begin
      ns_sum        = ns_inc + ptsu_pkg::NS_PER_SEC - ns_adj;
      next_time.ns  = ns_sum[ptsu_pkg::NS_W-1:0];
      next_time.sec = time_o.sec - host_i.value.sec - ptsu_pkg::SEC_ONE;
    end else begin
      if (host_i.adj) begin
        ns_sum = host_i.sub ? ns_inc - ns_adj : ns_inc + ns_adj;
        next_time.sec = host_i.sub ? time_o.sec - host_i.value.sec
                                   : time_o.sec + host_i.value.sec;
      end
      if (ns_sum >= ptsu_pkg::NS_PER_SEC) begin
        ns_sum        = ns_sum - ptsu_pkg::NS_PER_SEC;
        next_time.sec = next_time.sec + ptsu_pkg::SEC_ONE;
        next_sec_evt  = 1'b1;
      end
      next_time.ns = ns_sum[ptsu_pkg::NS_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      time_o    <= '0;
      sec_evt_o <= 1'b0;
    end else if (en_i) begin
      time_o    <= next_time;
      sec_evt_o <= next_sec_evt;
    end
  end

  // The start of frame is the timestamp point; the hold copy frees the
  // snapshot for a frame that starts right after this one ends.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      snap      <= '0;
      snap_hold <= '0;
    end else if (en_i) begin
      if (octet_i.valid && octet_i.sof) snap <= time_o;
      if (octet_i.valid && octet_i.eof) snap_hold <= snap;
    end
  end

  ptsu_frame_classifier u_classifier (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .en_i      (en_i),
    .octet_i   (octet_i),
    .hit_o     (hit),
    .kind_o    (kind)
  );

  for (genvar k = 0; k < ptsu_pkg::NUM_KINDS; k++) begin : g_cap
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        capture_o[k] <= '0;
      end else if (en_i && hit && kind == ptsu_pkg::ptsu_kind_t'(k)) begin
        capture_o[k] <= snap_hold;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      capture_evt_o  <= 1'b0;
      capture_kind_o <= ptsu_pkg::PTSU_SYNC;
    end else if (en_i) begin
      capture_evt_o  <= hit;
      capture_kind_o <= kind;
    end
  end

  sequence s_plain_step;
    en_i && !host_i.wr && !host_i.adj && !carry;
  endsequence

  sequence s_host_write;
    en_i && host_i.wr;
  endsequence

  AST_NS_RANGE: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    {2'h0, time_o.ns} < ptsu_pkg::NS_PER_SEC)
    else $error("Nanosecond field left its range.");

  AST_WRAP_SEC: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    s_plain_step ##0 (ns_inc >= ptsu_pkg::NS_PER_SEC)
    |=> time_o.sec == $past(time_o.sec) + ptsu_pkg::SEC_ONE
        && {2'h0, time_o.ns} == $past(ns_inc) - ptsu_pkg::NS_PER_SEC)
    else $error("Nanosecond wrap did not carry into seconds.");

  AST_SEC_EVENT: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    $past(en_i) && sec_evt_o |-> time_o.sec != $past(time_o.sec))
    else $error("Seconds event without a seconds change.");

  AST_CAPTURE_EVT: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    en_i && hit |=> capture_evt_o && capture_o[capture_kind_o]
                    == $past(snap_hold))
    else $error("Capture register not updated on event frame.");

  AST_HOST_WRITE: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    s_host_write |=> time_o == $past(host_i.value))
    else $error("Host write did not load the timer.");

  AST_STEP: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    s_plain_step ##0 (ns_inc < ptsu_pkg::NS_PER_SEC)
    |=> time_o.ns == $past(time_o.ns)
        + $past({22'h000000, timer_increment_setting_i}))
    else $error("Nanoseconds did not advance by the step.");

  AST_FRAC_ACC: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    en_i |=> frac == $past(frac) + $past(timer_increment_fraction_setting_i))
    else $error("Fraction accumulator did not advance.");

  AST_CARRY: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    en_i && !host_i.wr && !host_i.adj && carry
      && ns_inc < ptsu_pkg::NS_PER_SEC
    |=> time_o.ns == $past(time_o.ns)
        + $past({22'h000000, timer_increment_setting_i}) + 30'h00000001)
    else $error("Fraction overflow did not add a nanosecond.");

  AST_ADJ_ATOMIC: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    en_i && !host_i.wr && host_i.adj && !host_i.sub
      && ns_inc + ns_adj < ptsu_pkg::NS_PER_SEC
    |=> {2'h0, time_o.ns} == $past(ns_inc) + $past(ns_adj))
    else $error("Adjustment lost the cycle's increment.");

endmodule

/* src/ptsu_pkg.sv */
// Shared constants and types for the precision-time timestamp unit.
package ptsu_pkg;

  localparam int SEC_W  = 32;
  localparam int NS_W   = 30;
  localparam int FRAC_W = 16;
  localparam int STEP_W = 8;
  localparam int CNT_W  = 7;
  localparam int NUM_KINDS = 4;

  localparam logic [31:0] NS_PER_SEC  = 32'h3B9ACA00;
  localparam logic [SEC_W-1:0] SEC_ONE = 32'h00000001;

  localparam logic [47:0] DA_PTP_MCAST  = 48'h011B19000000;
  localparam logic [47:0] DA_PEER_MCAST = 48'h0180C200000E;
  localparam logic [15:0] ETYPE_PTP     = 16'h88F7;
  localparam logic [15:0] UDP_PORT_PTP  = 16'h013F;
  localparam logic [7:0]  PTP_VERSION   = 8'h02;

  localparam logic [3:0] MSG_SYNC   = 4'h0;
  localparam logic [3:0] MSG_DREQ   = 4'h1;
  localparam logic [3:0] MSG_PREQ   = 4'h2;
  localparam logic [3:0] MSG_PRESP  = 4'h3;

  localparam logic [CNT_W-1:0] OCT_DA_LAST  = 7'h05;
  localparam logic [CNT_W-1:0] OCT_ETYPE_HI = 7'h0C;
  localparam logic [CNT_W-1:0] OCT_ETYPE_LO = 7'h0D;
  localparam logic [CNT_W-1:0] OCT_MSG_RAW  = 7'h0E;
  localparam logic [CNT_W-1:0] OCT_VER_RAW  = 7'h0F;
  localparam logic [CNT_W-1:0] OCT_PORT_HI  = 7'h38;
  localparam logic [CNT_W-1:0] OCT_PORT_LO  = 7'h39;
  localparam logic [CNT_W-1:0] OCT_MSG_UDP  = 7'h3E;
  localparam logic [CNT_W-1:0] OCT_VER_UDP  = 7'h5E;
  localparam logic [CNT_W-1:0] CNT_MAX      = 7'h7F;

  typedef enum logic [1:0] {
    PTSU_SYNC,
    PTSU_DELAY_REQ,
    PTSU_PDELAY_REQ,
    PTSU_PDELAY_RESP
  } ptsu_kind_t;

  typedef struct packed {
    logic [SEC_W-1:0] sec;
    logic [NS_W-1:0]  ns;
  } ptsu_time_t;

  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic [7:0] data;
  } ptsu_octet_t;

  typedef struct packed {
    logic       wr;
    logic       adj;
    logic       sub;
    ptsu_time_t value;
  } ptsu_host_t;

endpackage

/* src/ptsu_frame_classifier.sv */
// Recognises PTP event frames in the MAC octet stream.
module ptsu_frame_classifier (
  input  wire logic                 sys_clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 en_i,
  input  wire ptsu_pkg::ptsu_octet_t octet_i,
  output logic                      hit_o,
  output ptsu_pkg::ptsu_kind_t      kind_o
);

  logic [ptsu_pkg::CNT_W-1:0] cnt;
  logic [ptsu_pkg::CNT_W-1:0] idx;
  logic [47:0]                da;
  logic [15:0]                etype;
  logic [15:0]                port;
  logic [7:0]                 msg_raw;
  logic [7:0]                 ver_raw;
  logic [7:0]                 msg_udp;
  logic [7:0]                 ver_udp;
  logic                       eval;
  logic                       next_hit;
  ptsu_pkg::ptsu_kind_t       next_kind;
  logic                       raw_ok;
  logic                       udp_ok;

  assign idx = octet_i.sof ? '0 : cnt;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= '0;
    end else if (en_i && octet_i.valid && idx != ptsu_pkg::CNT_MAX) begin
      cnt <= idx + 7'h01;
    end
  end

  // Header fields are picked out by octet position.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      da      <= '0;
      etype   <= '0;
      port    <= '0;
      msg_raw <= '0;
      ver_raw <= '0;
      msg_udp <= '0;
      ver_udp <= '0;
    end else if (en_i && octet_i.valid) begin
      if (idx <= ptsu_pkg::OCT_DA_LAST) da <= {da[39:0], octet_i.data};
      if (idx == ptsu_pkg::OCT_ETYPE_HI) etype[15:8] <= octet_i.data;
      if (idx == ptsu_pkg::OCT_ETYPE_LO) etype[7:0] <= octet_i.data;
      if (idx == ptsu_pkg::OCT_MSG_RAW) msg_raw <= octet_i.data;
      if (idx == ptsu_pkg::OCT_VER_RAW) ver_raw <= octet_i.data;
      if (idx == ptsu_pkg::OCT_PORT_HI) port[15:8] <= octet_i.data;
      if (idx == ptsu_pkg::OCT_PORT_LO) port[7:0] <= octet_i.data;
      if (idx == ptsu_pkg::OCT_MSG_UDP) msg_udp <= octet_i.data;
      if (idx == ptsu_pkg::OCT_VER_UDP) ver_udp <= octet_i.data;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      eval <= 1'b0;
    end else if (en_i) begin
      eval <= octet_i.valid && octet_i.eof;
    end
  end

  assign raw_ok = cnt > ptsu_pkg::OCT_VER_RAW
               && etype == ptsu_pkg::ETYPE_PTP
               && ver_raw == ptsu_pkg::PTP_VERSION;
  assign udp_ok = !raw_ok && cnt > ptsu_pkg::OCT_VER_UDP
               && port == ptsu_pkg::UDP_PORT_PTP
               && ver_udp == ptsu_pkg::PTP_VERSION;

  always_comb begin
    next_hit  = 1'b0;
    next_kind = ptsu_pkg::PTSU_SYNC;
    if (raw_ok && da == ptsu_pkg::DA_PTP_MCAST) begin
      case (msg_raw[3:0])
        ptsu_pkg::MSG_SYNC: begin
          next_hit = 1'b1;
        end
        ptsu_pkg::MSG_DREQ: begin
          next_hit  = 1'b1;
          next_kind = ptsu_pkg::PTSU_DELAY_REQ;
        end
        default: begin
          next_hit = 1'b0;
        end
      endcase
    end else if (raw_ok && da == ptsu_pkg::DA_PEER_MCAST) begin
      case (msg_raw[3:0])
        ptsu_pkg::MSG_SYNC: begin
          next_hit = 1'b1;
        end
        ptsu_pkg::MSG_PREQ: begin
          next_hit  = 1'b1;
          next_kind = ptsu_pkg::PTSU_PDELAY_REQ;
        end
        ptsu_pkg::MSG_PRESP: begin
          next_hit  = 1'b1;
          next_kind = ptsu_pkg::PTSU_PDELAY_RESP;
        end
        default: begin
          next_hit = 1'b0;
        end
      endcase
    end else if (udp_ok && msg_udp[7:2] == 6'h00) begin
      next_hit  = 1'b1;
      next_kind = ptsu_pkg::ptsu_kind_t'(msg_udp[1:0]);
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hit_o  <= 1'b0;
      kind_o <= ptsu_pkg::PTSU_SYNC;
    end else if (en_i) begin
      hit_o  <= eval && next_hit;
      kind_o <= next_kind;
    end
  end

  AST_PTP_DA_KIND: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    en_i && eval && raw_ok && da == ptsu_pkg::DA_PTP_MCAST
      && msg_raw[3:0] == ptsu_pkg::MSG_DREQ
    |=> hit_o && kind_o == ptsu_pkg::PTSU_DELAY_REQ)
    else $error("Delay request on PTP multicast not classified.");

  AST_PEER_DA_KIND: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    en_i && eval && raw_ok && da == ptsu_pkg::DA_PEER_MCAST
      && msg_raw[3:0] == ptsu_pkg::MSG_PRESP
    |=> hit_o && kind_o == ptsu_pkg::PTSU_PDELAY_RESP)
    else $error("Peer delay response not classified.");

  AST_RAW_ETYPE: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    en_i && eval && etype != ptsu_pkg::ETYPE_PTP && !udp_ok |=> !hit_o)
    else $error("Frame with wrong ethertype classified.");

  AST_UDP_PORT: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    en_i && eval && !raw_ok && port != ptsu_pkg::UDP_PORT_PTP |=> !hit_o)
    else $error("UDP frame with wrong port classified.");

endmodule

/* sim/ptsu_frame_src.sv */
// Behavioural MAC octet source that sends one frame per start request.
module ptsu_frame_src (
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             start_i,
  input  wire logic             udp_i,
  input  wire logic             slow_i,
  input  wire logic [47:0]      da_i,
  input  wire logic [15:0]      etype_i,
  input  wire logic [7:0]       msg_i,
  input  wire logic [7:0]       ver_i,
  input  wire logic [6:0]       len_i,
  output ptsu_pkg::ptsu_octet_t octet_o,
  output logic                  busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] idx;
  logic       gap;

  function automatic logic [7:0] octet_at(input logic [6:0] i);
    if (i < 7'h06) return 8'(da_i >> (8 * (5 - int'(i))));
    case (i)
      7'h0C: return etype_i[15:8];
      7'h0D: return etype_i[7:0];
      7'h0E: if (!udp_i) return msg_i;
      7'h0F: if (!udp_i) return ver_i;
      7'h38: if (udp_i) return 8'h01;
      7'h39: if (udp_i) return 8'h3F;
      7'h3E: if (udp_i) return msg_i;
      7'h5E: if (udp_i) return ver_i;
      default: ;
    endcase
    return 8'h5A ^ {1'b0, i};
  endfunction

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      octet_o <= '0;
      busy_o <= 1'b0;
      idx <= '0;
      gap <= 1'b0;
    end else begin
      // Idle data is inverted each cycle so a stale octet never matches.
      octet_o.valid <= 1'b0;
      octet_o.sof <= 1'b0;
      octet_o.eof <= 1'b0;
      octet_o.data <= ~octet_o.data;
      if (!busy_o) begin
        busy_o <= start_i;
        idx <= '0;
        gap <= 1'b0;
      end else if (slow_i && !gap) begin
        gap <= 1'b1;
      end else begin
        gap <= 1'b0;
        idx <= idx + 7'h01;
        busy_o <= idx != len_i - 7'h01;
        octet_o <= '{1'b1, idx == 7'h00, idx == len_i - 7'h01,
                     octet_at(idx)};
      end
    end
  end
endmodule

/* sim/ptsu_timestamp_unit_tb.sv */
// Self-checking bench for the timestamp unit with a frame source.
module ptsu_timestamp_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam longint NSS = longint'(ptsu_pkg::NS_PER_SEC);
  logic                  sys_clk_i = 1'b0, resetn_i = 1'b0, en_i = 1'b0;
  logic [7:0]            step = 8'h00;
  logic [15:0]           frac = 16'h0000;
  ptsu_pkg::ptsu_host_t  host = '0;
  ptsu_pkg::ptsu_octet_t octet;
  ptsu_pkg::ptsu_time_t  tm, stamp, ex_stamp;
  ptsu_pkg::ptsu_time_t  cap [ptsu_pkg::NUM_KINDS];
  ptsu_pkg::ptsu_kind_t  cap_kind;
  logic                  sec_evt, cap_evt, busy;
  logic                  start = 1'b0, f_udp = 1'b0, f_slow = 1'b0;
  logic [47:0]           f_da = '0;
  logic [15:0]           f_et = '0;
  logic [7:0]            f_msg = '0, f_ver = '0;
  logic [6:0]            f_len = 7'h10;
  logic [31:0]           m_sec = '0, r = 32'h00012789;
  logic [29:0]           m_ns = '0;
  logic [15:0]           m_frac = '0;
  logic                  m_evt = 1'b0;
  logic [2:0]            pv = '0, ex = '0;
  int                    err_count = 0, n_compared = 0, cyc = 0;

  ptsu_timestamp_unit u_dut (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .en_i(en_i),
    .timer_increment_setting_i(step),
    .timer_increment_fraction_setting_i(frac),
    .host_i(host), .octet_i(octet), .time_o(tm), .capture_o(cap),
    .sec_evt_o(sec_evt), .capture_evt_o(cap_evt),
    .capture_kind_o(cap_kind));

  ptsu_frame_src u_src (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .start_i(start),
    .udp_i(f_udp), .slow_i(f_slow), .da_i(f_da), .etype_i(f_et),
    .msg_i(f_msg), .ver_i(f_ver), .len_i(f_len), .octet_o(octet),
    .busy_o(busy));

  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'hA3000000 : s >> 1;
  endfunction

  function automatic logic [2:0] kind_of(input logic u,
      input logic [47:0] da, input logic [15:0] et,
      input logic [7:0] m, input logic [7:0] v, input logic [6:0] n);
    if (u) return {n >= 7'h5F && v == 8'h02 && m <= 8'h03, m[1:0]};
    if (n < 7'h10 || et != 16'h88F7 || v != 8'h02) return 3'h0;
    if (da == 48'h011B19000000 && m[3:0] <= 4'h1) return {1'b1, m[1:0]};
    if (da == 48'h0180C200000E && m[3:0] <= 4'h3 && m[3:0] != 4'h1)
      return {1'b1, m[1:0]};
    return 3'h0;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic hop(input logic [2:0] c, input logic [31:0] s,
                     input logic [29:0] ns);
    @(posedge sys_clk_i);
    host <= '{c[2], c[1], c[0], '{s, ns}};
  endtask

  task automatic send(input logic u, input logic [47:0] da,
      input logic [15:0] et, input logic [7:0] m, input logic [7:0] v,
      input logic [6:0] n, input logic slow);
    int k;
    @(posedge sys_clk_i);
    {f_udp, f_da, f_et, f_msg, f_ver, f_len} <= {u, da, et, m, v, n};
    f_slow <= slow;
    start <= 1'b1;
    @(posedge sys_clk_i);
    start <= 1'b0;
    k = 0;
    do begin
      @(negedge sys_clk_i);
      k++;
    end while (busy !== 1'b0 && k < 400);
  endtask

  always @(posedge sys_clk_i or negedge resetn_i) begin : ref_model
    logic [16:0] fs;
    longint n;
    if (!resetn_i) begin
      m_sec = '0;
      m_ns = '0;
      m_frac = '0;
      m_evt = 1'b0;
    end else if (en_i) begin
      fs = 17'(m_frac) + 17'(frac);
      m_frac = fs[15:0];
      m_evt = 1'b0;
      if (host.wr) begin
        m_sec = host.value.sec;
        m_ns = host.value.ns;
      end else begin
        n = longint'(m_ns) + longint'(step) + longint'(fs[16]);
        if (host.adj && host.sub) begin
          n = n - longint'(host.value.ns);
          m_sec = m_sec - host.value.sec;
        end else if (host.adj) begin
          n = n + longint'(host.value.ns);
          m_sec = m_sec + host.value.sec;
        end
        if (n >= NSS) begin
          n = n - NSS;
          m_sec = m_sec + 32'h1;
          m_evt = 1'b1;
        end else if (n < 0) begin
          n = n + NSS;
          m_sec = m_sec - 32'h1;
        end
        m_ns = n[29:0];
      end
    end
  end

  always @(negedge sys_clk_i) begin
    chk({2'b00, tm}, {2'b00, m_sec, m_ns});
    chk(64'(sec_evt), 64'(m_evt));
    if (pv[2] && ex[2]) begin
      chk(64'(cap_evt), 64'h1);
      chk(64'(cap_kind), 64'(ex[1:0]));
      chk({2'b00, cap[ex[1:0]]}, {2'b00, ex_stamp});
    end else begin
      chk(64'(cap_evt), 64'h0);
    end
    if (octet.valid && octet.sof) stamp = {m_sec, m_ns};
    if (octet.valid && octet.eof) begin
      ex = kind_of(f_udp, f_da, f_et, f_msg, f_ver, f_len);
      ex_stamp = stamp;
    end
    pv = {pv[1:0], octet.valid && octet.eof};
  end

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 12000) begin
      err_count++;
      test_done;
    end
  end

  initial begin
    logic [2:0] c;
    repeat (20) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    en_i <= 1'b1;
    step <= 8'hFF;
    hop(3'b100, 32'hFFFFFFFF, 30'h3B9AC9FF);
    hop(3'b110, 32'h00000005, 30'h3B9AC9F0);
    hop(3'b010, 32'h00000001, 30'h1DCD6500);
    hop(3'b011, 32'h00000002, 30'h3B9AC9F0);
    repeat (3000) begin
      r = lfsr(r);
      c = (r[5:3] == 3'h0) ? r[2:0] : 3'b000;
      step <= r[15:8];
      frac <= r[31:16];
      en_i <= r[7:6] != 2'b00;
      r = lfsr(r);
      hop(c, r, !c[2] ? {2'b00, r[27:0]} | 30'h200 : r[6] ?
          30'h3B9AC9FF - 30'(r[14:7]) : 30'(r % 32'h3B9ACA00));
    end
    @(posedge sys_clk_i);
    host <= '0;
    en_i <= 1'b1;
    for (int d = 0; d < 3; d++) begin
      for (int m = 0; m < 5; m++) begin
        send(1'b0, d == 0 ? 48'h011B19000000 : d == 1 ? 48'h0180C200000E
             : 48'h0180C2000000, 16'h88F7, 8'(m), 8'h02,
             7'h10 + 7'(m), m[0]);
      end
    end
    for (int m = 0; m < 5; m++) begin
      send(1'b1, 48'h0, 16'h86DD, 8'(m), 8'h02, 7'h5F, m[0]);
    end
    send(1'b0, 48'h011B19000000, 16'h88F8, 8'h00, 8'h02, 7'h10, 1'b0);
    send(1'b0, 48'h011B19000000, 16'h88F7, 8'h00, 8'h01, 7'h10, 1'b0);
    send(1'b0, 48'h011B19000000, 16'h88F7, 8'h00, 8'h02, 7'h0F, 1'b0);
    send(1'b1, 48'h0, 16'h86DD, 8'h00, 8'h03, 7'h5F, 1'b0);
    send(1'b1, 48'h0, 16'h86DD, 8'h00, 8'h02, 7'h5E, 1'b0);
    repeat (5) @(posedge sys_clk_i);
    test_done;
  end
endmodule
